// File: bts_pkg.sv
// shared constants and types for the burst-of-two sram port
package bts_pkg;
	localparam int BTS_WIDE_DATA_W = 36;
	localparam int BTS_NARROW_DATA_W = 18;
	localparam int BTS_WIDE_ADDR_W = 18;
	localparam int BTS_NARROW_ADDR_W = 19;
	localparam int BTS_LANE_W = 9;
	localparam int BTS_BURST_LEN = 2;
	localparam int BTS_RD_LATENCY = 2;
	localparam logic BTS_DIR_READ = 1'b1;
	localparam logic BTS_DIR_WRITE = 1'b0;
	localparam logic BTS_STROBE_IDLE = 1'b1;
	localparam logic BTS_LANES_OFF = 1'b1;
	typedef enum logic [1:0] {BTS_IDLE, BTS_WR2, BTS_RDW1, BTS_RDW2} bts_host_state_t;
endpackage

// File: bts_if.sv
// pin-level link between the controller and the sram model
`timescale 1ns/100ps
interface bts_if #(parameter int DW = 36, parameter int AW = 18, parameter int NL = 4);
	logic inClkPos;
	logic inClkNeg;
	logic outClkPos;
	logic outClkNeg;
	logic load_strobe_n;
	logic readNotWrite;
	logic [AW-1:0] addr;
	logic [NL-1:0] byte_lane_sel_n;
	logic [DW-1:0] wrData;
	logic [DW-1:0] rdData;
	logic rdDataOe;
	logic echo_strobe_pairPos;
	logic echo_strobe_pairNeg;
	modport device (input inClkPos, input inClkNeg, input outClkPos, input outClkNeg,
		input load_strobe_n, input readNotWrite, input addr, input byte_lane_sel_n,
		input wrData, output rdData, output rdDataOe, output echo_strobe_pairPos,
		output echo_strobe_pairNeg);
	modport host (output inClkPos, output inClkNeg, output outClkPos, output outClkNeg,
		output load_strobe_n, output readNotWrite, output addr, output byte_lane_sel_n,
		output wrData, input rdData, input rdDataOe, input echo_strobe_pairPos,
		input echo_strobe_pairNeg);
endinterface

// File: bts_device.sv
// sram end: burst-of-two storage with byte lanes, single clock model
`timescale 1ns/100ps
// Overview of operation
// - write data sampled on both clock phases
// - controller pulls load strobe low per access
// - each access moves exactly two words
// - direction high reads, low writes
// - lane selects sampled with their word
// - deselected lane leaves stored byte unchanged
// - lanes 0,1 cover bits 8:0, 17:9
// - wide adds lanes 26:18 and 35:27
// - address taken only at positive edge
// - address 19 bits narrow, 18 wide
// - storage is two paired equal arrays
// - address ignored when port deselected
// - read words launched on both output phases
// - read outputs released when port deselected
// - controller supplies output clock pair
// - accesses start at positive input edge
// - echo clock pair runs free
module bts_device #(
	parameter int DW = bts_pkg::BTS_WIDE_DATA_W,
	parameter int AW = bts_pkg::BTS_WIDE_ADDR_W,
	parameter int DEPTH = 1024
) (
	input wire logic clk,
	input wire logic reset,
	bts_if.device link
);
	localparam int NL = DW / bts_pkg::BTS_LANE_W;
	localparam int IW = $clog2(DEPTH);
	// one clk cycle models one input clock phase: phase 0 = positive edge, phase 1 = negative
	// model depth is a parameter; full array size is impractical in simulation
	logic [DW-1:0] arrayEven [DEPTH];
	logic [DW-1:0] arrayOdd [DEPTH];
	logic [IW-1:0] wrIdx_q;
	logic wrPending_q;
	logic [IW-1:0] rdIdx_q;
	logic rdPending_q;
	logic [DW-1:0] rdData_q;
	logic rdDataOe_q;
	logic echo_q;
	logic [DW-1:0] rdWord1_q;
	logic rdSecond_q;
	wire logic start = (link.load_strobe_n != bts_pkg::BTS_STROBE_IDLE);
	wire logic [IW-1:0] slot = link.addr[IW-1:0];
	// capture address only on a started access; otherwise it is ignored
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			wrPending_q <= 1'b0;
			rdPending_q <= 1'b0;
			wrIdx_q <= '0;
			rdIdx_q <= '0;
		end
		else
		begin
			wrPending_q <= start && link.readNotWrite == bts_pkg::BTS_DIR_WRITE;
			rdPending_q <= start && link.readNotWrite == bts_pkg::BTS_DIR_READ;
			if (start)
				wrIdx_q <= slot;
			if (start)
				rdIdx_q <= slot;
		end
	end
	// word 0 taken with the strobe edge, word 1 one cycle later (negative phase)
	logic [DW-1:0] wrWord0_q;
	logic [NL-1:0] wrLanes0_q;
	always_ff @(posedge clk)
	begin
		wrWord0_q <= link.wrData;
		wrLanes0_q <= link.byte_lane_sel_n;
	end
	// one process for both arrays: a lane-per-process split would give each array several drivers
	always_ff @(posedge clk)
	begin
		for (int g = 0; g < NL; g++)
		begin
			if (wrPending_q && wrLanes0_q[g] != bts_pkg::BTS_LANES_OFF)
				arrayEven[wrIdx_q][g*bts_pkg::BTS_LANE_W +: bts_pkg::BTS_LANE_W] <=
					wrWord0_q[g*bts_pkg::BTS_LANE_W +: bts_pkg::BTS_LANE_W];
			if (wrPending_q && link.byte_lane_sel_n[g] != bts_pkg::BTS_LANES_OFF)
				arrayOdd[wrIdx_q][g*bts_pkg::BTS_LANE_W +: bts_pkg::BTS_LANE_W] <=
					link.wrData[g*bts_pkg::BTS_LANE_W +: bts_pkg::BTS_LANE_W];
		end
	end
	// read: two consecutive words, then the bus is released
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rdData_q <= '0;
			rdDataOe_q <= 1'b0;
			rdSecond_q <= 1'b0;
			rdWord1_q <= '0;
		end
		else
		begin
			rdSecond_q <= rdPending_q;
			if (rdPending_q)
			begin
				rdData_q <= arrayEven[rdIdx_q];
				rdWord1_q <= arrayOdd[rdIdx_q];
				rdDataOe_q <= 1'b1;
			end
			else if (rdSecond_q)
			begin
				rdData_q <= rdWord1_q;
				rdDataOe_q <= 1'b1;
			end
			else
			begin
				rdData_q <= '0;
				rdDataOe_q <= 1'b0;
			end
		end
	end
	// echo toggles every cycle, independent of traffic
	always_ff @(posedge clk)
	begin
		if (reset)
			echo_q <= 1'b0;
		else
			echo_q <= ~echo_q;
	end
	assign link.rdData = rdData_q;
	assign link.rdDataOe = rdDataOe_q;
	assign link.echo_strobe_pairPos = echo_q;
	assign link.echo_strobe_pairNeg = ~echo_q;
endmodule

// File: bts_host.sv
// controller end: issues burst-of-two reads and writes on the link
`timescale 1ns/100ps
module bts_host #(
	parameter int DW = bts_pkg::BTS_WIDE_DATA_W,
	parameter int AW = bts_pkg::BTS_WIDE_ADDR_W,
	parameter int NL = DW / bts_pkg::BTS_LANE_W
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic reqValid,
	input wire logic reqRead,
	input wire logic [AW-1:0] reqAddr,
	input wire logic [DW-1:0] reqWord0,
	input wire logic [DW-1:0] reqWord1,
	input wire logic [NL-1:0] reqLanes0N,
	input wire logic [NL-1:0] reqLanes1N,
	output logic reqReady,
	output logic rspValid,
	output logic [DW-1:0] rspWord0,
	output logic [DW-1:0] rspWord1,
	bts_if.host link
);
	bts_pkg::bts_host_state_t state_q;
	logic loadN_q;
	logic dir_q;
	logic [AW-1:0] addr_q;
	logic [DW-1:0] wrData_q;
	logic [NL-1:0] lanes_q;
	logic [DW-1:0] word1_q;
	logic [NL-1:0] lanes1_q;
	logic clkPhase_q;
	logic reqReady_q;
	logic rspValid_q;
	logic [DW-1:0] rsp0_q;
	logic [DW-1:0] rsp1_q;
	wire logic take = reqValid && reqReady_q;
	// one write request per two cycles, one read per four; ready drops while a burst is in flight
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q <= bts_pkg::BTS_IDLE;
			loadN_q <= bts_pkg::BTS_STROBE_IDLE;
			dir_q <= bts_pkg::BTS_DIR_READ;
			addr_q <= '0;
			wrData_q <= '0;
			lanes_q <= '1;
			word1_q <= '0;
			lanes1_q <= '1;
			reqReady_q <= 1'b1;
		end
		else
		begin
			loadN_q <= ~take;
			unique case (state_q)
				bts_pkg::BTS_IDLE:
				begin
					lanes_q <= '1;
					if (take)
					begin
						dir_q <= reqRead ? bts_pkg::BTS_DIR_READ : bts_pkg::BTS_DIR_WRITE;
						addr_q <= reqAddr;
						wrData_q <= reqWord0;
						lanes_q <= reqRead ? '1 : reqLanes0N;
						word1_q <= reqWord1;
						lanes1_q <= reqRead ? '1 : reqLanes1N;
						reqReady_q <= 1'b0;
						state_q <= reqRead ? bts_pkg::BTS_RDW1 : bts_pkg::BTS_WR2;
					end
				end
				bts_pkg::BTS_WR2:
				begin
					wrData_q <= word1_q;
					lanes_q <= lanes1_q;
					reqReady_q <= 1'b1;
					state_q <= bts_pkg::BTS_IDLE;
				end
				bts_pkg::BTS_RDW1:
				begin
					lanes_q <= '1;
					state_q <= bts_pkg::BTS_RDW2;
				end
				bts_pkg::BTS_RDW2:
				begin
					if (link.rdDataOe)
					begin
						reqReady_q <= 1'b1;
						state_q <= bts_pkg::BTS_IDLE;
					end
				end
			endcase
		end
	end
	// collect the two returned words; second arrives the cycle after the first
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			rspValid_q <= 1'b0;
			rsp0_q <= '0;
			rsp1_q <= '0;
		end
		else
		begin
			rspValid_q <= 1'b0;
			if (state_q == bts_pkg::BTS_RDW2 && link.rdDataOe)
				rsp0_q <= link.rdData;
			if (state_q == bts_pkg::BTS_IDLE && link.rdDataOe)
			begin
				rsp1_q <= link.rdData;
				rspValid_q <= 1'b1;
			end
		end
	end
	always_ff @(posedge clk)
	begin
		if (reset)
			clkPhase_q <= 1'b0;
		else
			clkPhase_q <= ~clkPhase_q;
	end
	assign link.inClkPos = clkPhase_q;
	assign link.inClkNeg = ~clkPhase_q;
	assign link.outClkPos = clkPhase_q;
	assign link.outClkNeg = ~clkPhase_q;
	assign link.load_strobe_n = loadN_q;
	assign link.readNotWrite = dir_q;
	assign link.addr = addr_q;
	assign link.wrData = wrData_q;
	assign link.byte_lane_sel_n = lanes_q;
	assign reqReady = reqReady_q;
	assign rspValid = rspValid_q;
	assign rspWord0 = rsp0_q;
	assign rspWord1 = rsp1_q;
endmodule

// File: bts_link_props.sv
// link checker for the burst-of-two sram port
`timescale 1ns/100ps
module bts_link_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic load_strobe_n,
	input wire logic readNotWrite,
	input wire logic rdDataOe,
	input wire logic echo_strobe_pairPos,
	input wire logic echo_strobe_pairNeg
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	wire rdGo = !load_strobe_n && readNotWrite;
	wire wrGo = !load_strobe_n && !readNotWrite;
	a_read_two_words: assert property (rdGo |-> ##2 rdDataOe ##1 rdDataOe)
		else $error("read burst not driven on two cycles");
	a_burst_ends: assert property (rdDataOe && $past(rdDataOe) |=> !rdDataOe)
		else $error("read burst longer than two words");
	a_oe_has_cause: assert property (rdDataOe |-> $past(rdGo, 2) || $past(rdGo, 3))
		else $error("read data driven with no read access");
	a_write_released: assert property (wrGo |=> !rdDataOe)
		else $error("read data driven during a write");
	a_strobe_pulse: assert property (!load_strobe_n |=> load_strobe_n)
		else $error("load strobe held low two cycles");
	a_read_spacing: assert property (rdGo |=> load_strobe_n [*3])
		else $error("access started inside a read burst");
	a_echo_runs: assert property (!$past(reset) |-> $changed(echo_strobe_pairPos))
		else $error("echo clock stopped");
	a_echo_pair: assert property (echo_strobe_pairPos != echo_strobe_pairNeg)
		else $error("echo clocks not complementary");
	c_read: cover property (rdGo ##2 rdDataOe);
	c_write: cover property (wrGo);
	c_back2back: cover property (wrGo ##2 wrGo);
endmodule

// File: burst_two_sram_port_tb_top.sv
// testbench joining controller and sram ends
`timescale 1ns/100ps
module burst_two_sram_port_tb_top;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic reqValid = 1'b0;
	logic reqRead = 1'b0;
	logic [17:0] reqAddr = '0;
	logic [35:0] reqWord0 = '0;
	logic [35:0] reqWord1 = '0;
	logic [3:0] reqLanes0N = 4'hf;
	logic [3:0] reqLanes1N = 4'hf;
	logic reqReady;
	logic rspValid;
	logic [35:0] rspWord0;
	logic [35:0] rspWord1;
	int fail_count = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	bts_if #(.DW(36), .AW(18), .NL(4)) link ();
	bts_host bts_host_i (.clk(clk), .reset(reset), .reqValid(reqValid), .reqRead(reqRead),
		.reqAddr(reqAddr), .reqWord0(reqWord0), .reqWord1(reqWord1),
		.reqLanes0N(reqLanes0N), .reqLanes1N(reqLanes1N), .reqReady(reqReady),
		.rspValid(rspValid), .rspWord0(rspWord0), .rspWord1(rspWord1), .link(link));
	// small depth keeps the model cheap; addresses stay below it
	bts_device #(.DEPTH(16)) bts_device_i (.clk(clk), .reset(reset), .link(link));
	bts_link_props bts_link_props_i (.clk(clk), .reset(reset),
		.load_strobe_n(link.load_strobe_n), .readNotWrite(link.readNotWrite),
		.rdDataOe(link.rdDataOe), .echo_strobe_pairPos(link.echo_strobe_pairPos),
		.echo_strobe_pairNeg(link.echo_strobe_pairNeg));
	task automatic finish_test;
		$display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic req(input logic rd, input logic [17:0] a, input logic [35:0] w0,
		input logic [35:0] w1, input logic [3:0] l0, input logic [3:0] l1);
		int n;
		n = 0;
		@(negedge clk);
		{reqValid, reqRead, reqAddr, reqWord0, reqWord1} = {1'b1, rd, a, w0, w1};
		{reqLanes0N, reqLanes1N} = {l0, l1};
		while (reqReady !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 50)
		begin
			fail_count++;
			finish_test();
		end
		@(negedge clk);
		reqValid = 1'b0;
	endtask
	task automatic rd(input logic [17:0] a, input logic [35:0] e0, input logic [35:0] e1);
		int n;
		n = 0;
		req(1'b1, a, '0, '0, 4'hf, 4'hf);
		while (rspValid !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 50)
		begin
			fail_count++;
			finish_test();
		end
		chk(rspWord0, e0);
		chk(rspWord1, e1);
	endtask
	// lane with select low takes the new byte, others keep the old one
	function automatic logic [35:0] mrg(logic [35:0] o, logic [35:0] w, logic [3:0] l);
		for (int i = 0; i < 4; i++)
			if (!l[i])
				o[i*9 +: 9] = w[i*9 +: 9];
		return o;
	endfunction
	initial
	begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk({35'h0, link.rdDataOe}, 36'h0);
		req(1'b0, 18'h00003, 36'h123456789, 36'hfedcba987, 4'h0, 4'h0);
		req(1'b0, 18'h00009, 36'h0aaaa5555, 36'h055550aaa, 4'h0, 4'h0);
		rd(18'h00003, 36'h123456789, 36'hfedcba987);
		rd(18'h00009, 36'h0aaaa5555, 36'h055550aaa);
		req(1'b0, 18'h00003, 36'hfffffffff, 36'h000000000, 4'h5, 4'ha);
		rd(18'h00003, mrg(36'h123456789, '1, 4'h5), mrg(36'hfedcba987, '0, 4'ha));
		chk({35'h0, link.rdDataOe}, 36'h0);
		finish_test();
	end
	initial
	begin
		#20000;
		fail_count++;
		finish_test();
	end
endmodule
